/* File: bcpa_pkg.sv */
/*
 Constants and widths shared by the capture/accumulator core.
 Assumes a single clock domain; no bus, all control bits are plain ports.
*/
// Behaviour
// - Eight channels, capture or compare each
// - Select bit zero means capture channel
// - Four channels add 16-bit holding register
// - Register empty after read or latch
// - Plain channel captures, no-overwrite guards it
// - Latch mode moves capture on triggers
// - Latch mode overwrite governed by no-overwrite
// - Queue mode shifts old into holding
// - Queue no-overwrite writes only empty registers
// - Queue holding read latches accumulator, clears
// - Four 8-bit edge accumulators with holding
// - Saturate bit stops 8-bit accumulators at ones
// - Pairs combine into 16-bit accumulators
// - Latch mode moves count, clears accumulator
// - 16-bit modulus down-counter, 4-bit prescaler
// - Modulus zero gives periodic event
// - Modulus latching periodic or one-shot
// - Main timer prescaler is seven bits
// - Four selectable delays (one off) reject glitches
package bcpa_pkg;
   localparam int NUM_CH = 8;
   localparam int NUM_BUF = 4;
   localparam int TMR_W = 16;
   localparam int ACC_W = 8;
   localparam int MAIN_PRE_W = 7;
   localparam int MOD_PRE_W = 4;
   localparam int DLY_SEL_W = 2;
   localparam int DLY_CNT_W = 8;
   localparam int BUF_BASE = 0;
   localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
   localparam logic [ACC_W-1:0] ACC_ZERO = 8'h00;
   localparam logic [ACC_W-1:0] ACC_MAX = 8'hff;
   localparam logic [DLY_CNT_W-1:0] DLY_OFF = 8'h00;
   localparam logic [DLY_CNT_W-1:0] DLY_SHORT = 8'h04;
   localparam logic [DLY_CNT_W-1:0] DLY_MID = 8'h10;
   localparam logic [DLY_CNT_W-1:0] DLY_LONG = 8'h40;
endpackage : bcpa_pkg

/* File: bcpa_edge_if.sv */
/*
 Interface carrying filtered edge events from the input filter to the core.
 Assumes both ends in the same clock domain.
*/
`timescale 1ns/1ps
interface bcpa_edge_if;
   import bcpa_pkg::*;
   logic [NUM_CH-1:0] edgeHit;
   logic [NUM_CH-1:0] levelOk;
   modport src (output edgeHit, output levelOk);
   modport dst (input edgeHit, input levelOk);
endinterface : bcpa_edge_if

/* File: bcpa_input_filter.sv */
/*
 Delay-counter noise filter and edge detector for the channel inputs.
 Assumes synchronous inputs; pulses shorter than the chosen delay are dropped.
*/
`timescale 1ns/1ps
module bcpa_input_filter
   import bcpa_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [NUM_CH-1:0] pinIn,
   input wire logic [DLY_SEL_W-1:0] delaySel,
   input wire logic [2*NUM_CH-1:0] edgeCfg,
   bcpa_edge_if.src edges
);
   typedef struct packed {
      logic [NUM_CH-1:0] level;
      logic [NUM_CH-1:0][DLY_CNT_W-1:0] cnt;
      logic [NUM_CH-1:0] hit;
   } bcpa_flt_t;
   bcpa_flt_t st_q, st_d;
   logic [DLY_CNT_W-1:0] dly;

   always_comb begin
      case (delaySel)
         2'h1: dly = DLY_SHORT;
         2'h2: dly = DLY_MID;
         2'h3: dly = DLY_LONG;
         default: dly = DLY_OFF;
      endcase
   end

   // Level accepted only after it has held for the chosen count
   always_comb begin
      st_d = st_q;
      st_d.hit = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (pinIn[i] == st_q.level[i]) begin
            st_d.cnt[i] = DLY_OFF;
         end else if (st_q.cnt[i] >= dly) begin
            st_d.level[i] = pinIn[i];
            st_d.cnt[i] = DLY_OFF;
            st_d.hit[i] = pinIn[i] ? edgeCfg[2*i] : edgeCfg[2*i+1];
         end else begin
            st_d.cnt[i] = st_q.cnt[i] + 8'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign edges.edgeHit = st_q.hit;
   assign edges.levelOk = st_q.level;
endmodule : bcpa_input_filter

/* File: bcpa_modulus_counter.sv */
/*
 Modulus down-counter with its own prescaler; produces zero and latch events.
 Assumes the writer pulses load for one cycle.
*/
`timescale 1ns/1ps
module bcpa_modulus_counter
   import bcpa_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic enable,
   input wire logic periodic,
   input wire logic [MOD_PRE_W-1:0] preSel,
   input wire logic load,
   input wire logic [TMR_W-1:0] loadValue,
   output logic [TMR_W-1:0] count,
   output logic zeroPulse,
   output logic latchPulse
);
   typedef struct packed {
      logic [TMR_W-1:0] cnt;
      logic [TMR_W-1:0] reload;
      logic [MOD_PRE_W-1:0] pre;
      logic run;
      logic zero;
      logic latch;
   } bcpa_mod_t;
   bcpa_mod_t st_q, st_d;

   always_comb begin
      st_d = st_q;
      st_d.zero = 1'b0;
      st_d.latch = 1'b0;
      if (load) begin
         st_d.reload = loadValue;
         st_d.cnt = loadValue;
         st_d.pre = '0;
         st_d.run = (loadValue != TMR_ZERO);
         // Writing zero latches at once
         st_d.latch = (loadValue == TMR_ZERO);
      end else if (enable && st_q.run) begin
         // Prescaler divides by preSel plus one
         if (st_q.pre >= preSel) begin
            st_d.pre = '0;
            if (st_q.cnt == 16'h0001) begin
               st_d.zero = 1'b1;
               st_d.latch = 1'b1;
               st_d.cnt = periodic ? st_q.reload : TMR_ZERO;
               st_d.run = periodic;
            end else begin
               st_d.cnt = st_q.cnt - 16'h0001;
            end
         end else begin
            st_d.pre = st_q.pre + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign count = st_q.cnt;
   assign zeroPulse = st_q.zero;
   assign latchPulse = st_q.latch;
endmodule : bcpa_modulus_counter

/* File: bcpa_capture_core.sv */
/*
 Top of the buffered capture and pulse accumulator core.
 Assumes software pulses the read strobes for one cycle and reads 16-bit values whole.
*/
`timescale 1ns/1ps
module bcpa_capture_core
   import bcpa_pkg::*;
#(
   parameter int CHANNELS = NUM_CH,
   parameter int BUFFERED = NUM_BUF
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [NUM_CH-1:0] pinIn,
   input wire logic [NUM_CH-1:0] channelFunctionSelect,
   input wire logic [2*NUM_CH-1:0] edgeCfg,
   input wire logic [DLY_SEL_W-1:0] delaySel,
   input wire logic [NUM_CH-1:0] noOverwriteBits,
   input wire logic timerEnable,
   input wire logic [MAIN_PRE_W-1:0] mainPreSel,
   input wire logic latchQueueSelect,
   input wire logic accumulatorSaturateBit,
   input wire logic [NUM_BUF/2-1:0] accPairEnable,
   input wire logic [NUM_BUF-1:0] accEnable,
   input wire logic forceLatchBit,
   input wire logic modEnable,
   input wire logic modPeriodic,
   input wire logic [MOD_PRE_W-1:0] modPreSel,
   input wire logic modLoad,
   input wire logic [TMR_W-1:0] modLoadValue,
   input wire logic [NUM_CH-1:0] captureRead,
   input wire logic [NUM_BUF-1:0] holdRead,
   input wire logic [NUM_BUF-1:0] accRead,
   input wire logic [NUM_BUF-1:0] accHoldRead,
   input wire logic [NUM_CH-1:0] flagClear,
   output logic [TMR_W-1:0] mainCount,
   output logic [NUM_CH-1:0][TMR_W-1:0] captureValue,
   output logic [NUM_BUF-1:0][TMR_W-1:0] holdValue,
   output logic [NUM_BUF-1:0][ACC_W-1:0] accValue,
   output logic [NUM_BUF-1:0][ACC_W-1:0] accHoldValue,
   output logic [NUM_CH-1:0] captureFlag,
   output logic [TMR_W-1:0] modCount,
   output logic modZeroFlag
);
   // Refused at elaboration: the logic is unrolled for the documented counts only
   if (CHANNELS != NUM_CH || BUFFERED != NUM_BUF || BUFFERED > CHANNELS) begin : g_bad_counts
      $error("bcpa_capture_core: unsupported channel counts");
   end

   typedef struct packed {
      logic [TMR_W-1:0] tmr;
      logic [MAIN_PRE_W-1:0] pre;
      logic [NUM_CH-1:0][TMR_W-1:0] cap;
      logic [NUM_CH-1:0] capFull;
      logic [NUM_BUF-1:0][TMR_W-1:0] hold;
      logic [NUM_BUF-1:0] holdFull;
      logic [NUM_BUF-1:0][ACC_W-1:0] acc;
      logic [NUM_BUF-1:0][ACC_W-1:0] accHold;
      logic [NUM_CH-1:0] flag;
      logic modFlag;
   } bcpa_core_t;
   bcpa_core_t st_q, st_d;

   logic modZero;
   logic modLatch;
   logic latchNow;

   bcpa_edge_if edges ();

   bcpa_input_filter u_filter (
      .clk(clk),
      .reset(reset),
      .pinIn(pinIn),
      .delaySel(delaySel),
      .edgeCfg(edgeCfg),
      .edges(edges.src)
   );

   bcpa_modulus_counter u_mod (
      .clk(clk),
      .reset(reset),
      .enable(modEnable),
      .periodic(modPeriodic),
      .preSel(modPreSel),
      .load(modLoad),
      .loadValue(modLoadValue),
      .count(modCount),
      .zeroPulse(modZero),
      .latchPulse(modLatch)
   );

   // Modulus zero, zero write or force-latch all trigger latching
   assign latchNow = modLatch | forceLatchBit;

   ////////////////////////////////////////////////////////////////////////////
   // Saturating or wrapping increment of one 8-bit accumulator
   function automatic logic [ACC_W-1:0] accInc(input logic [ACC_W-1:0] v, input logic sat);
      if (sat && v == ACC_MAX) begin
         accInc = v;
      end else begin
         accInc = v + 8'h01;
      end
   endfunction : accInc

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [NUM_CH-1:0] capEv;
      logic [ACC_W:0] wide;
      int b;
      capEv = '0;
      wide = '0;
      b = 0;
      st_d = st_q;

      // Main timer with 7-bit prescaler
      if (timerEnable) begin
         if (st_q.pre >= mainPreSel) begin
            st_d.pre = '0;
            st_d.tmr = st_q.tmr + 16'h0001;
         end else begin
            st_d.pre = st_q.pre + 7'h01;
         end
      end

      // Reads empty the registers; a same-cycle capture below still wins
      for (int i = 0; i < NUM_CH; i++) begin
         if (captureRead[i]) begin
            st_d.capFull[i] = 1'b0;
         end
      end
      for (int j = 0; j < NUM_BUF; j++) begin
         if (holdRead[j]) begin
            st_d.holdFull[j] = 1'b0;
         end
      end

      // Only channels selected as capture (select bit zero) capture and flag on edges
      capEv = edges.edgeHit & ~channelFunctionSelect;

      // Latch transfer, ahead of new captures in the same cycle
      if (latchQueueSelect && latchNow) begin
         for (int j = 0; j < NUM_BUF; j++) begin
            b = BUF_BASE + j;
            if (st_q.capFull[b] && (!noOverwriteBits[b] || !st_d.holdFull[j])) begin
               st_d.hold[j] = st_q.cap[b];
               st_d.holdFull[j] = 1'b1;
               st_d.capFull[b] = 1'b0;
            end
         end
      end

      for (int i = 0; i < NUM_CH; i++) begin
         if (capEv[i]) begin
            st_d.flag[i] = 1'b1;
            if (i >= BUF_BASE && i < BUF_BASE + NUM_BUF && !latchQueueSelect) begin
               // Queue: old capture moves to holding first
               if (!noOverwriteBits[i]) begin
                  if (st_q.capFull[i]) begin
                     st_d.hold[i-BUF_BASE] = st_q.cap[i];
                     st_d.holdFull[i-BUF_BASE] = 1'b1;
                  end
                  st_d.cap[i] = st_q.tmr;
                  st_d.capFull[i] = 1'b1;
               end else if (!st_d.holdFull[i-BUF_BASE] && st_q.capFull[i] && !captureRead[i]) begin
                  st_d.hold[i-BUF_BASE] = st_q.cap[i];
                  st_d.holdFull[i-BUF_BASE] = 1'b1;
                  st_d.cap[i] = st_q.tmr;
               end else if (!st_d.capFull[i]) begin
                  st_d.cap[i] = st_q.tmr;
                  st_d.capFull[i] = 1'b1;
               end
               // Otherwise blocked: both values kept
            end else begin
               // Plain channel or latch mode capture register
               if (!noOverwriteBits[i] || !st_d.capFull[i]) begin
                  st_d.cap[i] = st_q.tmr;
                  st_d.capFull[i] = 1'b1;
               end
            end
         end
      end

      // Accumulator reads and counting
      for (int j = 0; j < NUM_BUF; j++) begin
         if (accHoldRead[j] || accRead[j]) begin
            st_d.accHold[j] = st_d.accHold[j];
         end
      end
      for (int p = 0; p < NUM_BUF / 2; p++) begin
         if (accPairEnable[p]) begin
            // Upper counts carry out of lower; no saturation in 16-bit mode
            if (accEnable[2*p] && edges.edgeHit[BUF_BASE+2*p]) begin
               wide = {1'b0, st_q.acc[2*p]} + 9'h001;
               st_d.acc[2*p] = wide[ACC_W-1:0];
               if (wide[ACC_W]) begin
                  st_d.acc[2*p+1] = st_q.acc[2*p+1] + 8'h01;
               end
            end
         end else begin
            for (int k = 0; k < 2; k++) begin
               if (accEnable[2*p+k] && edges.edgeHit[BUF_BASE+2*p+k]) begin
                  st_d.acc[2*p+k] = accInc(st_q.acc[2*p+k], accumulatorSaturateBit);
               end
            end
         end
      end

      // Accumulator transfer and clear: latch on trigger, queue on holding read
      for (int j = 0; j < NUM_BUF; j++) begin
         if ((latchQueueSelect && latchNow) || (!latchQueueSelect && holdRead[j])) begin
            st_d.accHold[j] = st_q.acc[j];
            st_d.acc[j] = ACC_ZERO;
         end
      end

      // Flags: set wins over a clear in the same cycle
      for (int i = 0; i < NUM_CH; i++) begin
         if (flagClear[i] && !capEv[i]) begin
            st_d.flag[i] = 1'b0;
         end
      end
      if (modZero) begin
         st_d.modFlag = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Whole 16-bit words come straight from flops, stable for a word read
   assign mainCount = st_q.tmr;
   assign captureValue = st_q.cap;
   assign holdValue = st_q.hold;
   assign accValue = st_q.acc;
   assign accHoldValue = st_q.accHold;
   assign captureFlag = st_q.flag;
   assign modZeroFlag = st_q.modFlag;
endmodule : bcpa_capture_core

/* File: bcpa_pin_model.sv */
/*
 Far-side model of the channel input pins: drives a pulse of a chosen width.
 Assumes requests arrive by non-blocking assignment just after a clock edge.
*/
`timescale 1ns/1ps
module bcpa_pin_model
   import bcpa_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [NUM_CH-1:0] pulseReq,
   input wire logic [7:0] pulseWidth,
   output logic [NUM_CH-1:0] pinOut
);
   logic [7:0] cnt_q;
   ////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (reset) begin
         pinOut <= '0;
         cnt_q <= 8'h00;
      end else if (cnt_q == 8'h00 && pulseReq != '0) begin
         pinOut <= pulseReq;
         cnt_q <= pulseWidth;
      end else if (cnt_q == 8'h01) begin
         // Pins idle low between pulses, like a real sensor line
         pinOut <= '0;
         cnt_q <= 8'h00;
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule : bcpa_pin_model

/* File: bcpa_capture_core_props.sv */
/*
 Concurrent checks on the capture core ports.
 Assumes it is bound to the core and sees only its ports.
*/
`timescale 1ns/1ps
module bcpa_capture_core_props
   import bcpa_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [NUM_CH-1:0] channelFunctionSelect,
   input wire logic [NUM_CH-1:0] noOverwriteBits,
   input wire logic timerEnable,
   input wire logic latchQueueSelect,
   input wire logic accumulatorSaturateBit,
   input wire logic [NUM_BUF/2-1:0] accPairEnable,
   input wire logic forceLatchBit,
   input wire logic modEnable,
   input wire logic modLoad,
   input wire logic [NUM_BUF-1:0] holdRead,
   input wire logic [NUM_CH-1:0] flagClear,
   input wire logic [TMR_W-1:0] mainCount,
   input wire logic [NUM_CH-1:0][TMR_W-1:0] captureValue,
   input wire logic [NUM_BUF-1:0][ACC_W-1:0] accValue,
   input wire logic [NUM_BUF-1:0][ACC_W-1:0] accHoldValue,
   input wire logic [NUM_CH-1:0] captureFlag,
   input wire logic modZeroFlag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////
   capture_time_a:
      assert property ($rose(captureFlag[4]) && !$past(noOverwriteBits[4]) |-> captureValue[4] == $past(mainCount))
      else $error("capture value differs from timer");
   compare_ignore_a:
      assert property (channelFunctionSelect[5] [*3] |=> $stable(captureValue[5]))
      else $error("compare channel captured");
   timer_step_a:
      assert property (!$stable(mainCount) |-> mainCount == $past(mainCount) + 16'h0001)
      else $error("timer moved by more than one");
   timer_hold_a:
      assert property (!timerEnable [*2] |=> $stable(mainCount))
      else $error("timer counted while disabled");
   acc_step_a:
      assert property (!$stable(accValue[1]) |-> accValue[1] == $past(accValue[1]) + 8'h01 || accValue[1] == ACC_ZERO)
      else $error("accumulator jumped");
   sat_stop_a:
      assert property (accumulatorSaturateBit && !accPairEnable[1] && accValue[3] == ACC_MAX && !forceLatchBit
         && !modLoad && !$past(modLoad) && !modEnable && !holdRead[3] |=> accValue[3] == ACC_MAX)
      else $error("saturated accumulator left all ones");
   force_latch_a:
      assert property (forceLatchBit && latchQueueSelect && !noOverwriteBits[2]
         |=> accHoldValue[2] == $past(accValue[2]) && accValue[2] == ACC_ZERO)
      else $error("forced latch did not move count");
   queue_read_a:
      assert property (holdRead[1] && !latchQueueSelect |=> accHoldValue[1] == $past(accValue[1]) && accValue[1] == ACC_ZERO)
      else $error("holding read did not move count");
   flag_clear_a:
      assert property ($fell(captureFlag[2]) |-> $past(flagClear[2]))
      else $error("flag dropped without clear");
   zero_sticky_a:
      assert property (modZeroFlag |=> modZeroFlag)
      else $error("zero flag dropped");
endmodule : bcpa_capture_core_props

bind bcpa_capture_core bcpa_capture_core_props props_u (.*);

/* File: test_buffered_capture_pulse_accumulator.sv */
/*
 Self-checking bench for the capture core with a pin model on the inputs.
 Assumes the package constants and a 100 MHz clock.
*/
`timescale 1ns/1ps
module test_buffered_capture_pulse_accumulator;
   import bcpa_pkg::*;
   typedef struct {logic [4:0] sel; logic [15:0] val;} bcpa_exp_t;
   logic clk = 1'b0, reset = 1'b1, timerEnable = 1'b0, latchQueueSelect = 1'b0, accumulatorSaturateBit = 1'b0;
   logic forceLatchBit = 1'b0, modEnable = 1'b0, modPeriodic = 1'b0, modLoad = 1'b0, modZeroFlag;
   logic [7:0] pinIn, channelFunctionSelect = 8'h00, noOverwriteBits = 8'h00, captureRead = 8'h00;
   logic [7:0] flagClear = 8'h00, captureFlag, pulseReq = 8'h00, pulseWidth = 8'h04;
   logic [15:0] edgeCfg = 16'h5555, modLoadValue = 16'h0000, mainCount, modCount;
   logic [1:0] delaySel = 2'h0, accPairEnable = 2'h0;
   logic [6:0] mainPreSel = 7'h00;
   logic [3:0] modPreSel = 4'h0, holdRead = 4'h0, accRead = 4'h0, accHoldRead = 4'h0, accEnable = 4'h0;
   logic [7:0][15:0] captureValue;
   logic [3:0][15:0] holdValue;
   logic [3:0][7:0] accValue, accHoldValue;
   bcpa_exp_t expQ[$], e;
   int err_total = 0, check_count = 0, cycles = 0, seed = 93, w, n;
   bcpa_capture_core dut_u (.*);
   bcpa_pin_model pins_u (.clk, .reset, .pulseReq, .pulseWidth, .pinOut(pinIn));
   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////
   function automatic logic [15:0] seen(input logic [4:0] s);
      case (s)
         5'h14: return {8'h00, captureFlag};
         5'h15: return {15'h0000, modZeroFlag};
         5'h16: return mainCount; // Whole-word reads only
         5'h17: return captureValue[7] - captureValue[6];
         5'h18: return captureValue[0] - holdValue[0];
         5'h19: return holdValue[2] - captureValue[2];
         5'h1a: return modCount;
         default: return (s < 5'h0c) ? {8'h00, accValue[s[1:0]]} : {8'h00, accHoldValue[s[1:0]]};
      endcase
   endfunction : seen
   task automatic chk(input logic [15:0] a, input logic [15:0] b);
      check_count++;
      if (a !== b) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, a, b);
      end
   endtask : chk
   task automatic note(input logic [4:0] s, input logic [15:0] v);
      expQ.push_back('{s, v});
      @(negedge clk);
   endtask : note
   // Watcher settles one note per falling edge, oldest first
   always @(negedge clk) begin
      if (expQ.size() != 0) begin
         e = expQ.pop_front();
         chk(seen(e.sel), e.val);
      end
   end
   task automatic pulse(input logic [7:0] m, input logic [7:0] wd);
      @(posedge clk);
      pulseReq <= m;
      pulseWidth <= wd;
      @(posedge clk);
      pulseReq <= 8'h00;
      // Fixed spacing: pulse starts are wd+16 clocks apart
      repeat (wd + 14) @(posedge clk);
   endtask : pulse
   task automatic strobe(input int k);
      @(posedge clk);
      flagClear <= (k == 0) ? 8'hff : 8'h00;
      holdRead <= (k == 1) ? 4'h2 : 4'h0;
      {accRead, accHoldRead} <= (k == 1) ? 8'h22 : 8'h00;
      forceLatchBit <= (k == 2);
      captureRead <= (k == 3) ? 8'h40 : 8'h00;
      modLoad <= (k == 4);
      @(posedge clk);
      {flagClear, holdRead, accRead, accHoldRead, forceLatchBit, captureRead, modLoad} <= '0;
      repeat (3) @(posedge clk);
   endtask : strobe
   task automatic stop_test();
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      note(5'h14, 16'h0000);
      note(5'h16, 16'h0000);
      note(5'h15, 16'h0000);
      @(posedge clk) timerEnable <= 1'b1;
      delaySel <= 2'h1;
      pulse(8'h10, 8'h02);
      note(5'h14, 16'h0000);
      pulse(8'h10, 8'h0a);
      note(5'h14, 16'h0010);
      strobe(0);
      @(posedge clk) delaySel <= 2'h0;
      channelFunctionSelect <= 8'h20;
      noOverwriteBits <= 8'h40;
      w = 1 + ($random(seed) & 7);
      pulse(8'he0, 8'(w));
      pulse(8'he0, 8'h04);
      note(5'h14, 16'h00c0);
      note(5'h17, 16'(w + 16));
      strobe(3);
      pulse(8'hc0, 8'h04);
      note(5'h17, 16'h0000);
      pulse(8'h01, 8'(w));
      pulse(8'h01, 8'h03);
      note(5'h18, 16'(w + 16));
      // Twenty clocks at divide-by-four give five ticks whatever the phase
      @(posedge clk) mainPreSel <= 7'h03;
      pulse(8'h01, 8'h04);
      pulse(8'h01, 8'h04);
      note(5'h18, 16'h0005);
      @(posedge clk) mainPreSel <= 7'h00;
      accEnable <= 4'hf;
      // Channel 1 counts both edges
      edgeCfg <= 16'h555d;
      n = 2 + ($random(seed) & 7);
      repeat (n) pulse(8'h02, 8'h02);
      note(5'h09, 16'(2 * n));
      strobe(1);
      note(5'h0d, 16'(2 * n));
      note(5'h09, 16'h0000);
      @(posedge clk) latchQueueSelect <= 1'b1;
      edgeCfg <= 16'h5555;
      repeat (n) pulse(8'h04, 8'h02);
      strobe(2);
      note(5'h0e, 16'(n));
      note(5'h0a, 16'h0000);
      note(5'h19, 16'h0000);
      strobe(0);
      note(5'h14, 16'h0000);
      @(posedge clk) accumulatorSaturateBit <= 1'b1;
      accPairEnable <= 2'h1;
      repeat (260) pulse(8'h09, 8'h01);
      note(5'h0b, 16'h00ff);
      note(5'h08, 16'h0004);
      note(5'h09, 16'h0001);
      @(posedge clk) accumulatorSaturateBit <= 1'b0;
      modEnable <= 1'b1;
      pulse(8'h04, 8'h02);
      strobe(4);
      note(5'h0e, 16'h0001);
      @(posedge clk) modLoadValue <= 16'h001e;
      strobe(4);
      repeat (40) @(posedge clk);
      note(5'h15, 16'h0001);
      note(5'h1a, 16'h0000);
      // Periodic at divide-by-two: one after the reload, zero if one-shot
      @(posedge clk) modLoadValue <= 16'h000a;
      modPeriodic <= 1'b1;
      modPreSel <= 4'h1;
      strobe(4);
      repeat (36) @(posedge clk);
      note(5'h1a, 16'h0001);
      // Let the watcher take the last note before the verdict
      @(posedge clk);
      stop_test();
   end
endmodule : test_buffered_capture_pulse_accumulator
